// File: hw/torque_overload_monitor.sv
// Motor overload alarm, torque-reached detection and output polarity inversion.
`timescale 1ns/1ps
module torque_overload_monitor #(
    parameter int MS_CYCLES        = torque_overload_pkg::MS_CYCLES,
    parameter int OVERLOAD_QUAL_MS = torque_overload_pkg::OVERLOAD_QUAL_MS
) (
    // Clock, reset and clock enable.
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ce,
    // Parameter access port.
    input  wire logic        paramWrite,
    input  wire logic        paramRead,
    input  wire logic [15:0] paramIndex,
    input  wire logic [15:0] paramWrData,
    output logic [15:0]      paramRdData,
    output logic             paramRdValid,
    output logic             paramError,
    // Measurements and motor type.
    input  wire logic [15:0] loadPercent,
    input  wire logic [15:0] torquePercent,
    input  wire logic        fixedThresholdMotor,
    // Alarm and detection.
    input  wire logic        alarmClear,
    output logic             motor_overload_alarm,
    output logic             torque_limit_detect_out,
    // Digital output pin pairs.
    input  wire logic [3:0]  outPinsRaw,
    output logic [3:0]       outPins
);

    logic [15:0] overload_start_threshold_reg;
    logic [15:0] output_polarity_select_reg;
    logic [15:0] torque_detect_level_reg;
    logic [15:0] torque_detect_time_reg;
    logic [15:0] effThreshold;
    logic        overloadCond;
    logic        overloadQual;
    logic        torqueCond;
    logic        torqueQual;
    logic        hitThreshold;
    logic        hitPolarity;
    logic        hitLevel;
    logic        hitTime;
    logic        wrOk;
    logic        polarityLegal;
    logic [15:0] rdData_next;
    logic [3:0]  polarityBits;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode and range checks.
    // An unmapped index leaves every hit low, so its writes are refused and its reads give 0.
    assign hitThreshold = (paramIndex == torque_overload_pkg::IDX_OVERLOAD_START_THRESHOLD);
    assign hitPolarity  = (paramIndex == torque_overload_pkg::IDX_OUTPUT_POLARITY_SELECT);
    assign hitLevel     = (paramIndex == torque_overload_pkg::IDX_TORQUE_DETECT_LEVEL);
    assign hitTime      = (paramIndex == torque_overload_pkg::IDX_TORQUE_DETECT_TIME);

    // Each decimal digit of the polarity setting must be 0 or 1, so only bits 0, 4, 8, 12.
    assign polarityLegal = ((paramWrData & 16'hEEEE) == 16'h0000);

    always_comb begin
        wrOk = 1'b0;
        if (hitThreshold) begin
            wrOk = (paramWrData >= torque_overload_pkg::OVERLOAD_MIN)
                && (paramWrData <= torque_overload_pkg::OVERLOAD_MAX);
        end else if (hitPolarity) begin
            wrOk = polarityLegal;
        end else if (hitLevel) begin
            wrOk = (paramWrData >= torque_overload_pkg::TORQUE_LEVEL_MIN)
                && (paramWrData <= torque_overload_pkg::TORQUE_LEVEL_MAX);
        end else if (hitTime) begin
            wrOk = (paramWrData >= torque_overload_pkg::TORQUE_TIME_MIN)
                && (paramWrData <= torque_overload_pkg::TORQUE_TIME_MAX);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Parameter storage; accepted writes act from the next cycle.
    // Out-of-range values are refused rather than clamped, so a setting keeps its last legal
    // value. The advised ceiling for the overload threshold is left to the host.
    always_ff @(posedge clk) begin
        if (srst) begin
            overload_start_threshold_reg <= torque_overload_pkg::RST_OVERLOAD_START_THRESHOLD;
            output_polarity_select_reg   <= torque_overload_pkg::RST_OUTPUT_POLARITY_SELECT;
            torque_detect_level_reg      <= torque_overload_pkg::RST_TORQUE_DETECT_LEVEL;
            torque_detect_time_reg       <= torque_overload_pkg::RST_TORQUE_DETECT_TIME;
        end else if (ce && paramWrite && wrOk) begin
            if (hitThreshold) begin
                overload_start_threshold_reg <= paramWrData;
            end
            if (hitPolarity) begin
                output_polarity_select_reg <= paramWrData;
            end
            if (hitLevel) begin
                torque_detect_level_reg <= paramWrData;
            end
            if (hitTime) begin
                torque_detect_time_reg <= paramWrData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read port and error flag.
    // A read in the same cycle as a write is dropped, since the write has priority.
    always_comb begin
        rdData_next = 16'h0000;
        if (hitThreshold) begin
            rdData_next = overload_start_threshold_reg;
        end else if (hitPolarity) begin
            rdData_next = output_polarity_select_reg;
        end else if (hitLevel) begin
            rdData_next = torque_detect_level_reg;
        end else if (hitTime) begin
            rdData_next = torque_detect_time_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            paramRdData  <= 16'h0000;
            paramRdValid <= 1'b0;
        end else if (ce) begin
            paramRdValid <= paramRead && !paramWrite;
            if (paramRead && !paramWrite) begin
                paramRdData <= rdData_next;
            end
        end
    end

    // A write that is out of range or unmapped, or an unmapped read, pulses the error flag.
    always_ff @(posedge clk) begin
        if (srst) begin
            paramError <= 1'b0;
        end else if (ce) begin
            paramError <= (paramWrite && !wrOk)
                || (paramRead && !paramWrite && !(hitThreshold || hitPolarity || hitLevel || hitTime));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Motor overload detection.
    // The fixed threshold overrides the stored one only while the motor input is high; the
    // stored value is kept and applies again once the input drops.
    assign effThreshold = fixedThresholdMotor ? torque_overload_pkg::OVERLOAD_FIXED
                                              : overload_start_threshold_reg;
    assign overloadCond = (loadPercent > effThreshold);

    persist_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_overload_timer (
        .clk       (clk),
        .srst      (srst),
        .ce        (ce),
        .cond      (overloadCond),
        .limitMs   (16'(OVERLOAD_QUAL_MS)),
        .qualified (overloadQual)
    );

    // The alarm latches until cleared; a new overload wins over a clear in the same cycle.
    // A clear therefore only sticks once the qualified overload has ended.
    always_ff @(posedge clk) begin
        if (srst) begin
            motor_overload_alarm <= 1'b0;
        end else if (ce) begin
            if (overloadQual) begin
                motor_overload_alarm <= 1'b1;
            end else if (alarmClear) begin
                motor_overload_alarm <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Torque-reached detection.
    // The output is gated by the live condition so that it drops in the cycle in which the
    // timer restarts, not one cycle later.
    assign torqueCond = (torquePercent > torque_detect_level_reg);

    persist_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_torque_timer (
        .clk       (clk),
        .srst      (srst),
        .ce        (ce),
        .cond      (torqueCond),
        .limitMs   (torque_detect_time_reg),
        .qualified (torqueQual)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            torque_limit_detect_out <= 1'b0;
        end else if (ce) begin
            torque_limit_detect_out <= torqueQual && torqueCond;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output polarity: digit n of the setting sits at bit 4n.
    genvar p;
    generate
        for (p = 0; p < torque_overload_pkg::POLARITY_PAIRS; p++) begin : g_pol
            assign polarityBits[p] = output_polarity_select_reg[p * torque_overload_pkg::POLARITY_DIGIT_W];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            outPins <= 4'h0;
        end else if (ce) begin
            outPins <= outPinsRaw ^ polarityBits;
        end
    end

endmodule

// File: hw/torque_overload_pkg.sv
// Package with parameter indices, field layouts, reset values and timing constants.
package torque_overload_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Parameter indices.
    localparam logic [15:0] IDX_OVERLOAD_START_THRESHOLD = 16'h3371;
    localparam logic [15:0] IDX_OUTPUT_POLARITY_SELECT   = 16'h3374;
    localparam logic [15:0] IDX_TORQUE_DETECT_LEVEL      = 16'h3375;
    localparam logic [15:0] IDX_TORQUE_DETECT_TIME       = 16'h3376;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [15:0] RST_OVERLOAD_START_THRESHOLD = 16'h0064;
    localparam logic [15:0] RST_OUTPUT_POLARITY_SELECT   = 16'h0000;
    localparam logic [15:0] RST_TORQUE_DETECT_LEVEL      = 16'h0064;
    localparam logic [15:0] RST_TORQUE_DETECT_TIME       = 16'h000A;

    ////////////////////////////////////////////////////////////////////////////////
    // Legal ranges and fixed values.
    localparam logic [15:0] OVERLOAD_MIN        = 16'h0064;
    localparam logic [15:0] OVERLOAD_MAX        = 16'h0096;
    localparam logic [15:0] OVERLOAD_FIXED      = 16'h0073;
    localparam logic [15:0] TORQUE_LEVEL_MIN    = 16'h0003;
    localparam logic [15:0] TORQUE_LEVEL_MAX    = 16'h012C;
    localparam logic [15:0] TORQUE_TIME_MIN     = 16'h0001;
    localparam logic [15:0] TORQUE_TIME_MAX     = 16'h03E8;

    ////////////////////////////////////////////////////////////////////////////////
    // Polarity field layout: one digit per output pin pair, one bit per digit.
    localparam int          POLARITY_PAIRS      = 4;
    localparam int          POLARITY_DIGIT_W    = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int          CLK_PERIOD_NS       = 4;
    localparam int          MS_NS               = 1000000;
    localparam int          MS_CYCLES           = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          PRESCALE_W          = 18;
    localparam int          OVERLOAD_QUAL_MS    = 1000;

    ////////////////////////////////////////////////////////////////////////////////
    // Qualification timer states, Gray coded along idle, timing, qualified.
    typedef enum logic [1:0] {
        QUAL_IDLE   = 2'b00,
        QUAL_TIMING = 2'b01,
        QUAL_DONE   = 2'b11
    } qual_state_e;

endpackage

// File: hw/persist_timer.sv
// Qualification timer: flags a condition that has held longer than a limit in milliseconds.
`timescale 1ns/1ps
module persist_timer #(
    parameter int MS_CYCLES = torque_overload_pkg::MS_CYCLES
) (
    // Clock and control.
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ce,
    // Condition and limit.
    input  wire logic        cond,
    input  wire logic [15:0] limitMs,
    // Result.
    output logic             qualified
);

    torque_overload_pkg::qual_state_e                state_reg;
    logic [torque_overload_pkg::PRESCALE_W-1:0]      prescale_reg;
    logic [15:0]                                     msCount_reg;
    logic                                            msTick;

    assign msTick    = (prescale_reg == torque_overload_pkg::PRESCALE_W'(MS_CYCLES - 1));
    assign qualified = (state_reg == torque_overload_pkg::QUAL_DONE);

    ////////////////////////////////////////////////////////////////////////////////
    // The prescaler restarts with the condition so that every counted millisecond is whole.
    always_ff @(posedge clk) begin
        if (srst) begin
            prescale_reg <= '0;
        end else if (ce) begin
            if (!cond || msTick) begin
                prescale_reg <= '0;
            end else begin
                prescale_reg <= prescale_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            msCount_reg <= 16'h0000;
        end else if (ce) begin
            if (!cond) begin
                msCount_reg <= 16'h0000;
            end else if (msTick && msCount_reg != 16'hFFFF) begin
                msCount_reg <= msCount_reg + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Done is entered one cycle after the full limit has elapsed, so the time is exceeded.
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= torque_overload_pkg::QUAL_IDLE;
        end else if (ce) begin
            unique case (state_reg)
                torque_overload_pkg::QUAL_IDLE: begin
                    if (cond) begin
                        state_reg <= torque_overload_pkg::QUAL_TIMING;
                    end
                end
                torque_overload_pkg::QUAL_TIMING: begin
                    if (!cond) begin
                        state_reg <= torque_overload_pkg::QUAL_IDLE;
                    end else if (msCount_reg >= limitMs) begin
                        state_reg <= torque_overload_pkg::QUAL_DONE;
                    end
                end
                torque_overload_pkg::QUAL_DONE: begin
                    if (!cond) begin
                        state_reg <= torque_overload_pkg::QUAL_IDLE;
                    end
                end
                default: begin
                    state_reg <= torque_overload_pkg::QUAL_IDLE;
                end
            endcase
        end
    end

endmodule

// File: bench/torque_overload_props.sv
// Checker for the torque and overload monitor ports.
`timescale 1ns/1ps
module torque_overload_props #(
    parameter int MS_CYCLES        = 4,
    parameter int OVERLOAD_QUAL_MS = 2
) (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        ce,
    input wire logic        paramWrite,
    input wire logic        paramRead,
    input wire logic [15:0] paramIndex,
    input wire logic [15:0] paramWrData,
    input wire logic        paramRdValid,
    input wire logic        paramError,
    input wire logic [15:0] loadPercent,
    input wire logic [15:0] torquePercent,
    input wire logic        alarmClear,
    input wire logic        motor_overload_alarm,
    input wire logic        torque_limit_detect_out,
    input wire logic [3:0]  outPinsRaw,
    input wire logic [3:0]  outPins
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic [15:0] lvl, pol, torqRun, loadRun;
    wire         wrOk   = ce && paramWrite;
    wire         rdOk   = ce && paramRead && !paramWrite;
    wire  [3:0]  polBits = {pol[12], pol[8], pol[4], pol[0]};
    ////////////////////////////////////////////////////////////////////////////////
    // Shadow copies of accepted level and polarity writes.
    always_ff @(posedge clk) begin
        if (srst) begin
            lvl <= 16'h0064;
            pol <= 16'h0000;
        end else if (wrOk && paramIndex == 16'h3375 && paramWrData >= 16'h0003
                     && paramWrData <= 16'h012C) begin
            lvl <= paramWrData;
        end else if (wrOk && paramIndex == 16'h3374 && (paramWrData & 16'hEEEE) == 16'h0000) begin
            pol <= paramWrData;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Lengths of the current runs of each condition.
    always_ff @(posedge clk) begin
        if (srst || !(torquePercent > lvl)) torqRun <= 16'h0000;
        else if (ce && torqRun != 16'hFFFF) torqRun <= torqRun + 16'h0001;
    end
    always_ff @(posedge clk) begin
        if (srst || !(loadPercent > 16'h0064)) loadRun <= 16'h0000;
        else if (ce && loadRun != 16'hFFFF) loadRun <= loadRun + 16'h0001;
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_read_answer: assert property (rdOk |=> paramRdValid)
        else $error("read not answered");
    a_valid_pulse: assert property (ce && !rdOk |=> !paramRdValid)
        else $error("stray read valid");
    a_write_refused: assert property (wrOk && paramIndex == 16'h3371 && (paramWrData < 16'h0064
        || paramWrData > 16'h0096) |=> paramError)
        else $error("bad threshold accepted");
    a_write_accept: assert property (wrOk && paramIndex == 16'h3375 && paramWrData >= 16'h0003
        && paramWrData <= 16'h012C |=> !paramError)
        else $error("good level refused");
    a_pins_invert: assert property (ce |=> outPins == ($past(outPinsRaw) ^ $past(polBits)))
        else $error("output polarity wrong");
    a_detect_drop: assert property (ce && !(torquePercent > lvl) |=> !torque_limit_detect_out)
        else $error("detect output held");
    a_detect_rise: assert property ($rose(torque_limit_detect_out) |-> $past(torqRun, 2) >= MS_CYCLES)
        else $error("detect output early");
    a_alarm_cause: assert property ($rose(motor_overload_alarm)
        |-> $past(loadRun, 2) >= MS_CYCLES * OVERLOAD_QUAL_MS)
        else $error("alarm without overload");
    a_alarm_sticky: assert property (motor_overload_alarm && !alarmClear |=> motor_overload_alarm)
        else $error("alarm dropped");
    c_detect: cover property ($rose(torque_limit_detect_out));
    c_alarm: cover property ($rose(motor_overload_alarm));
    c_error: cover property (paramError);
endmodule

// File: bench/param_host.sv
// Host model that drives the parameter access port.
`timescale 1ns/1ps
module param_host (
    input  wire logic        clk,
    output logic             paramWrite,
    output logic             paramRead,
    output logic [15:0]      paramIndex,
    output logic [15:0]      paramWrData,
    input  wire logic [15:0] paramRdData,
    input  wire logic        paramRdValid,
    input  wire logic        paramError
);
    initial begin
        paramWrite = 1'b0;
        paramRead = 1'b0;
        paramIndex = 16'h0000;
        paramWrData = 16'h0000;
    end
    // One access; idle lines show inverted values so stale data is never mistaken.
    task automatic access(input logic wr, input logic [15:0] idx, input logic [15:0] dat,
                          output logic [15:0] rdat, output logic vld, output logic err);
        @(negedge clk);
        paramWrite = wr;
        paramRead = !wr;
        paramIndex = idx;
        paramWrData = dat;
        @(negedge clk);
        paramWrite = 1'b0;
        paramRead = 1'b0;
        paramIndex = ~idx;
        paramWrData = ~dat;
        rdat = paramRdData;
        vld = paramRdValid;
        err = paramError;
    endtask
endmodule

// File: bench/torque_overload_monitor_tb.sv
// Self-checking bench for the torque and overload monitor.
`timescale 1ns/1ps
module torque_overload_monitor_tb;
    logic clk, srst, ce, paramWrite, paramRead, paramRdValid, paramError;
    logic [15:0] paramIndex, paramWrData, paramRdData, loadPercent, torquePercent;
    logic fixedThresholdMotor, alarmClear, motor_overload_alarm, torque_limit_detect_out;
    logic [3:0] outPinsRaw, outPins;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [15:0] regIdx [4] = '{16'h3371, 16'h3374, 16'h3375, 16'h3376};
    logic [15:0] regDef [4] = '{16'h0064, 16'h0000, 16'h0064, 16'h000A};
    logic [15:0] goodDat [4] = '{16'h0096, 16'h1111, 16'h012C, 16'h03E8};
    logic [15:0] badIdx [5] = '{16'h3371, 16'h3371, 16'h3375, 16'h3376, 16'h3374};
    logic [15:0] badDat [5] = '{16'h0063, 16'h0097, 16'h012D, 16'h0000, 16'h0002};
    torque_overload_monitor #(.MS_CYCLES(4), .OVERLOAD_QUAL_MS(2)) dut (
        .clk(clk), .srst(srst), .ce(ce), .paramWrite(paramWrite), .paramRead(paramRead),
        .paramIndex(paramIndex), .paramWrData(paramWrData), .paramRdData(paramRdData),
        .paramRdValid(paramRdValid), .paramError(paramError), .loadPercent(loadPercent),
        .torquePercent(torquePercent), .fixedThresholdMotor(fixedThresholdMotor),
        .alarmClear(alarmClear), .motor_overload_alarm(motor_overload_alarm),
        .torque_limit_detect_out(torque_limit_detect_out), .outPinsRaw(outPinsRaw),
        .outPins(outPins));
    param_host host (
        .clk(clk), .paramWrite(paramWrite), .paramRead(paramRead), .paramIndex(paramIndex),
        .paramWrData(paramWrData), .paramRdData(paramRdData), .paramRdValid(paramRdValid),
        .paramError(paramError));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [15:0] dat, input logic errExp);
        logic [15:0] d;
        logic v, e;
        host.access(1'b1, idx, dat, d, v, e);
        check("write error", {15'h0000, e}, {15'h0000, errExp});
    endtask
    task automatic rd(input logic [15:0] idx, input logic [15:0] exp, input logic errExp);
        logic [15:0] d;
        logic v, e;
        host.access(1'b0, idx, 16'h0000, d, v, e);
        check("read valid", {15'h0000, v}, 16'h0001);
        check("read data", d, exp);
        check("read error", {15'h0000, e}, {15'h0000, errExp});
    endtask
    // Sel picks the output looked at after n falling edges: 0 pins, 1 detect, 2 alarm.
    task automatic wait_chk(input int n, input string what, input int sel, input logic [15:0] exp);
        logic [15:0] seen;
        repeat (n) @(negedge clk);
        seen = (sel == 0) ? {12'h000, outPins}
             : (sel == 1) ? {15'h0000, torque_limit_detect_out} : {15'h0000, motor_overload_alarm};
        check(what, seen, exp);
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            wrap_up();
        end
    end
    initial begin
        srst = 1'b1;
        ce = 1'b1;
        loadPercent = 16'h0000;
        torquePercent = 16'h0000;
        fixedThresholdMotor = 1'b0;
        alarmClear = 1'b0;
        outPinsRaw = 4'hA;
        repeat (10) @(negedge clk);
        srst = 1'b0;
        rd(16'h3372, 16'h0000, 1'b1);
        for (int i = 0; i < 5; i++) wr(badIdx[i], badDat[i], 1'b1);
        for (int i = 0; i < 4; i++) rd(regIdx[i], regDef[i], 1'b0);
        for (int i = 0; i < 4; i++) wr(regIdx[i], goodDat[i], 1'b0);
        for (int i = 0; i < 4; i++) rd(regIdx[i], goodDat[i], 1'b0);
        wait_chk(1, "pins all inverted", 0, 16'h0005);
        wr(16'h3374, 16'h0101, 1'b0);
        wait_chk(1, "pins two inverted", 0, 16'h000F);
        ce = 1'b0;
        outPinsRaw = 4'h0;
        wait_chk(2, "pins frozen", 0, 16'h000F);
        ce = 1'b1;
        wait_chk(1, "pins after enable", 0, 16'h0005);
        wr(16'h3376, 16'h0001, 1'b0);
        wr(16'h3375, 16'h00C8, 1'b0);
        torquePercent = 16'h00C9;
        wait_chk(5, "detect early", 1, 16'h0000);
        wait_chk(1, "detect on", 1, 16'h0001);
        torquePercent = 16'h00C8;
        wait_chk(1, "detect at level", 1, 16'h0000);
        torquePercent = 16'h00C9;
        wait_chk(5, "detect restart", 1, 16'h0000);
        torquePercent = 16'h0000;
        wr(16'h3371, 16'h0078, 1'b0);
        loadPercent = 16'h0074;
        wait_chk(20, "alarm below threshold", 2, 16'h0000);
        fixedThresholdMotor = 1'b1;
        wait_chk(9, "alarm early", 2, 16'h0000);
        wait_chk(1, "alarm fixed threshold", 2, 16'h0001);
        loadPercent = 16'h0000;
        fixedThresholdMotor = 1'b0;
        alarmClear = 1'b1;
        wait_chk(1, "alarm set wins", 2, 16'h0001);
        wait_chk(1, "alarm cleared", 2, 16'h0000);
        alarmClear = 1'b0;
        loadPercent = 16'h0079;
        wait_chk(20, "alarm above threshold", 2, 16'h0001);
        wrap_up();
    end
endmodule
bind torque_overload_monitor torque_overload_props #(.MS_CYCLES(MS_CYCLES),
    .OVERLOAD_QUAL_MS(OVERLOAD_QUAL_MS)) props (
    .clk(clk), .srst(srst), .ce(ce), .paramWrite(paramWrite), .paramRead(paramRead),
    .paramIndex(paramIndex), .paramWrData(paramWrData), .paramRdValid(paramRdValid),
    .paramError(paramError), .loadPercent(loadPercent), .torquePercent(torquePercent),
    .alarmClear(alarmClear), .motor_overload_alarm(motor_overload_alarm),
    .torque_limit_detect_out(torque_limit_detect_out), .outPinsRaw(outPinsRaw),
    .outPins(outPins));
